//--- itpj_pkg.sv
package itpj_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ITPJ_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] ITPJ_HSIZE_ADDR   = 8'h04;
  localparam logic [7:0] ITPJ_VSIZE_ADDR   = 8'h08;
  localparam logic [7:0] ITPJ_HRAMP_ADDR   = 8'h0C;
  localparam logic [7:0] ITPJ_VRAMP_ADDR   = 8'h10;
  localparam logic [7:0] ITPJ_JIT_ADDR     = 8'h14;
  localparam logic [7:0] ITPJ_STAT_ADDR    = 8'h18;
  localparam logic [7:0] ITPJ_OFFS_ADDR    = 8'h1C;
  // ==========================================================
  // control and status bit positions
  localparam int ITPJ_B_INFORM   = 0;
  localparam int ITPJ_B_TESTPIC  = 1;
  localparam int ITPJ_B_ILACE    = 2;
  localparam int ITPJ_B_SWAP     = 3;
  localparam int ITPJ_B_BORDER   = 4;
  localparam int ITPJ_B_INVERT   = 5;
  localparam int ITPJ_B_HRAMP    = 8;
  localparam int ITPJ_B_VRAMP    = 11;
  localparam int ITPJ_B_JIT_EN   = 16;
  localparam int ITPJ_B_FIELD    = 1;
  localparam logic [31:0] ITPJ_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ITPJ_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  ITPJ_RESP_OK  = 2'h0;
  localparam logic [1:0]  ITPJ_RESP_ERR = 2'h2;
  localparam logic [7:0]  ITPJ_WHITE    = 8'hFF;
  localparam logic [11:0] ITPJ_ONE      = 12'h001;
  // ==========================================================
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } itpj_pix_t;
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic valid;
  } itpj_sync_t;
  typedef enum logic [1:0] {
    ITPJ_BUS_IDLE = 2'b00,
    ITPJ_BUS_RESP = 2'b01
  } itpj_bus_t;
endpackage

//--- itpj_top.sv
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - interlace: field polarity from per-frame line count
// - test picture sized by sample lengths plus blanking
// - totals set line period and frame height
// - sample offsets ignored in test mode
// - per-colour ramp enables gate each pattern
// - border enable drives all three colours
// - pixel is border plus horizontal plus vertical
// - invert bit-reverses every colour
// - horizontal on column, vertical on line
// - add increment every rise interval
// - nonzero fall position subtracts decrement, then alternates
// - colour arithmetic wraps, never saturates
// - jitter compares low two bits of line length
// - mismatch with previous line is one event
// - events accumulated per frame against limit
// - normal monitoring only inside sampled area
// - disabled interface monitors always
// - jitter irq has state, enable, clear
// - state set past limit, held to vsync
// - test mode forces generated pixels out
// - flag clears on write one to state bit
module itpj_top
  import itpj_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // axi4-lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // sampled source
  input  wire itpj_pkg::itpj_pix_t   src_pix,
  input  wire itpj_pkg::itpj_sync_t  src_sync,
  // pixel stream out
  output itpj_pkg::itpj_pix_t        out_pix,
  output logic                       out_valid,
  output logic                       out_field,
  output logic                       jitter_irq
);
  import itpj_pkg::*;

  // ==========================================================
  // registers
  logic [31:0] ctrl_reg, hsize_reg, vsize_reg, hramp_reg, vramp_reg, jit_reg, offs_reg;
  logic        irq_state_reg;
  logic        field_reg;
  itpj_bus_t   wst_reg, rst_reg;
  logic        aw_got_reg, w_got_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  logic        clr_write;

  // ==========================================================
  // axi write path; address and data taken in either order
  assign s_axi_awready = (wst_reg == ITPJ_BUS_IDLE) && !aw_got_reg;
  assign s_axi_wready  = (wst_reg == ITPJ_BUS_IDLE) && !w_got_reg;
  assign s_axi_bvalid  = (wst_reg == ITPJ_BUS_RESP);
  assign do_write = (wst_reg == ITPJ_BUS_IDLE)
                    && (aw_got_reg || s_axi_awvalid) && (w_got_reg || s_axi_wvalid);

  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  assign wa = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign wd = w_got_reg ? wdata_reg : s_axi_wdata;
  assign ws = w_got_reg ? wstrb_reg : s_axi_wstrb;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wst_reg     <= ITPJ_BUS_IDLE;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= ITPJ_ZERO;
      wstrb_reg   <= 4'h0;
      s_axi_bresp <= ITPJ_RESP_OK;
    end
    else
    begin
      case (wst_reg)
        ITPJ_BUS_IDLE:
        begin
          if (do_write)
          begin
            wst_reg    <= ITPJ_BUS_RESP;
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            s_axi_bresp <= (wa > ITPJ_OFFS_ADDR || wa[1:0] != 2'b00)
                           ? ITPJ_RESP_ERR : ITPJ_RESP_OK;
          end
          else
          begin
            if (s_axi_awvalid)
            begin
              aw_got_reg <= 1'b1;
              awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid)
            begin
              w_got_reg <= 1'b1;
              wdata_reg <= s_axi_wdata;
              wstrb_reg <= s_axi_wstrb;
            end
          end
        end
        ITPJ_BUS_RESP:
        begin
          if (s_axi_bready)
            wst_reg <= ITPJ_BUS_IDLE;
        end
        default: wst_reg <= ITPJ_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_reg  <= ITPJ_CTRL_RST;
      hsize_reg <= ITPJ_ZERO;
      vsize_reg <= ITPJ_ZERO;
      hramp_reg <= ITPJ_ZERO;
      vramp_reg <= ITPJ_ZERO;
      jit_reg   <= ITPJ_ZERO;
      offs_reg  <= ITPJ_ZERO;
    end
    else if (do_write)
    begin
      case (wa)
        ITPJ_CTRL_ADDR:  ctrl_reg  <= merge(ctrl_reg, wd, ws);
        ITPJ_HSIZE_ADDR: hsize_reg <= merge(hsize_reg, wd, ws);
        ITPJ_VSIZE_ADDR: vsize_reg <= merge(vsize_reg, wd, ws);
        ITPJ_HRAMP_ADDR: hramp_reg <= merge(hramp_reg, wd, ws);
        ITPJ_VRAMP_ADDR: vramp_reg <= merge(vramp_reg, wd, ws);
        ITPJ_JIT_ADDR:   jit_reg   <= merge(jit_reg, wd, ws);
        ITPJ_OFFS_ADDR:  offs_reg  <= merge(offs_reg, wd, ws);
        default: ;
      endcase
    end
  end
  assign clr_write = do_write && (wa == ITPJ_STAT_ADDR) && ws[0] && wd[0];

  // ==========================================================
  // axi read path
  assign s_axi_arready = (rst_reg == ITPJ_BUS_IDLE);
  assign s_axi_rvalid  = (rst_reg == ITPJ_BUS_RESP);
  logic [31:0] stat_word;
  logic        irq_en;
  assign irq_en    = ctrl_reg[ITPJ_B_JIT_EN];
  assign stat_word = {30'h0000_0000, field_reg, irq_state_reg & irq_en};

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rst_reg     <= ITPJ_BUS_IDLE;
      s_axi_rdata <= ITPJ_ZERO;
      s_axi_rresp <= ITPJ_RESP_OK;
    end
    else
    begin
      case (rst_reg)
        ITPJ_BUS_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rst_reg     <= ITPJ_BUS_RESP;
            s_axi_rresp <= ITPJ_RESP_OK;
            case (s_axi_araddr)
              ITPJ_CTRL_ADDR:  s_axi_rdata <= ctrl_reg;
              ITPJ_HSIZE_ADDR: s_axi_rdata <= hsize_reg;
              ITPJ_VSIZE_ADDR: s_axi_rdata <= vsize_reg;
              ITPJ_HRAMP_ADDR: s_axi_rdata <= hramp_reg;
              ITPJ_VRAMP_ADDR: s_axi_rdata <= vramp_reg;
              ITPJ_JIT_ADDR:   s_axi_rdata <= jit_reg;
              ITPJ_STAT_ADDR:  s_axi_rdata <= stat_word;
              ITPJ_OFFS_ADDR:  s_axi_rdata <= offs_reg;
              default:
              begin
                s_axi_rdata <= ITPJ_ZERO;
                s_axi_rresp <= ITPJ_RESP_ERR;
              end
            endcase
          end
        end
        ITPJ_BUS_RESP:
        begin
          if (s_axi_rready)
            rst_reg <= ITPJ_BUS_IDLE;
        end
        default: rst_reg <= ITPJ_BUS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // register fields
  logic        in_form_on, test_on, ilace_on, swap, border_on, invert;
  logic [2:0]  hramp_en, vramp_en;
  logic [11:0] h_len, h_total, v_len, v_total, v_off;
  assign in_form_on = ctrl_reg[ITPJ_B_INFORM];
  assign test_on    = ctrl_reg[ITPJ_B_TESTPIC];
  assign ilace_on   = ctrl_reg[ITPJ_B_ILACE];
  assign swap       = ctrl_reg[ITPJ_B_SWAP];
  assign border_on  = ctrl_reg[ITPJ_B_BORDER];
  assign invert     = ctrl_reg[ITPJ_B_INVERT];
  assign hramp_en   = ctrl_reg[ITPJ_B_HRAMP +: 3];
  assign vramp_en   = ctrl_reg[ITPJ_B_VRAMP +: 3];
  assign h_len   = hsize_reg[11:0];
  assign h_total = hsize_reg[27:16];
  assign v_len   = vsize_reg[11:0];
  assign v_total = vsize_reg[27:16];
  assign v_off   = offs_reg[27:16];

  // ==========================================================
  // test picture timing; offsets deliberately unused here
  logic [11:0] col_reg, row_reg;
  logic        g_vs, g_act;
  always_ff @(posedge sys_clk)
  begin
    if (reset || !test_on)
    begin
      col_reg <= 12'h000;
      row_reg <= 12'h000;
    end
    else if (col_reg + ITPJ_ONE >= h_total)
    begin
      col_reg <= 12'h000;
      row_reg <= (row_reg + ITPJ_ONE >= v_total) ? 12'h000 : row_reg + ITPJ_ONE;
    end
    else
      col_reg <= col_reg + ITPJ_ONE;
  end
  assign g_act = (col_reg < h_len) && (row_reg < v_len);
  assign g_vs  = (row_reg == 12'h000) && (col_reg == 12'h000);

  // ==========================================================
  // ramp and ripple, one engine per axis
  logic [7:0] ramp_val [2];
  logic        rst_axis [2];
  assign rst_axis[0] = (col_reg == 12'h000);
  assign rst_axis[1] = g_vs;
  generate
    for (genvar a = 0; a < 2; a++)
    begin : g_axis
      logic [31:0] cfg;
      logic [7:0]  cnt_reg, colour_reg;
      logic        fall_reg;
      logic [7:0]  rise_iv, fall_pos, inc, dec;
      logic        adv;
      assign cfg      = (a == 0) ? hramp_reg : vramp_reg;
      assign rise_iv  = cfg[7:0];
      assign fall_pos = cfg[15:8];
      assign inc      = cfg[23:16];
      assign dec      = cfg[31:24];
      // vertical engine steps once per line only
      assign adv = (a == 0) ? 1'b1 : (col_reg == 12'h000);
      always_ff @(posedge sys_clk)
      begin
        if (reset || rst_axis[a] && (a == 0 || g_vs))
        begin
          cnt_reg    <= 8'h00;
          colour_reg <= 8'h00;
          fall_reg   <= 1'b0;
        end
        else if (adv)
        begin
          if (!fall_reg && cnt_reg + 8'h01 >= rise_iv)
          begin
            colour_reg <= colour_reg + inc;
            cnt_reg    <= 8'h00;
            fall_reg   <= (fall_pos != 8'h00);
          end
          else if (fall_reg && cnt_reg + 8'h01 >= fall_pos)
          begin
            colour_reg <= colour_reg - dec;
            cnt_reg    <= 8'h00;
            fall_reg   <= 1'b0;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
      end
      assign ramp_val[a] = colour_reg;
    end
  endgenerate

  // ==========================================================
  // colour sum, one per component
  logic [7:0] gen_c [3];
  logic       border_px;
  assign border_px = border_on && (col_reg == 12'h000 || row_reg == 12'h000
                     || col_reg + ITPJ_ONE == h_len || row_reg + ITPJ_ONE == v_len);
  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_col
      logic [7:0] sum;
      logic [7:0] rev;
      assign sum = (border_px ? ITPJ_WHITE : 8'h00)
                   + (hramp_en[c] ? ramp_val[0] : 8'h00)
                   + (vramp_en[c] ? ramp_val[1] : 8'h00);
      // streaming result needs its own net before it may feed a mux
      assign rev      = {<<{sum}};
      assign gen_c[c] = invert ? rev : sum;
    end
  endgenerate

  // ==========================================================
  // source sync pins pass three flops
  itpj_sync_t s1_reg, s2_reg, s3_reg;
  itpj_pix_t  p1_reg, p2_reg;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      p1_reg <= '0;
      p2_reg <= '0;
    end
    else
    begin
      s1_reg <= src_sync;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      p1_reg <= src_pix;
      p2_reg <= p1_reg;
    end
  end
  logic hs_rise, vs_rise;
  assign hs_rise = s2_reg.hsync && !s3_reg.hsync;
  assign vs_rise = s2_reg.vsync && !s3_reg.vsync;

  // ==========================================================
  // pixel output
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      out_pix   <= '0;
      out_valid <= 1'b0;
    end
    else if (test_on)
    begin
      out_pix   <= '{r: gen_c[2], g: gen_c[1], b: gen_c[0]};
      out_valid <= g_act;
    end
    else
    begin
      out_pix   <= p2_reg;
      out_valid <= in_form_on && s2_reg.valid;
    end
  end

  // ==========================================================
  // field identification by comparing line count with the previous frame's
  logic [11:0] lines_reg, prev_lines_reg;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      lines_reg      <= 12'h000;
      prev_lines_reg <= 12'h000;
      field_reg      <= 1'b0;
    end
    else if (vs_rise)
    begin
      lines_reg      <= 12'h000;
      prev_lines_reg <= lines_reg;
      // even field is the longer one unless swapped
      if (ilace_on)
        field_reg <= (lines_reg > prev_lines_reg) ^ swap;
    end
    else if (hs_rise)
      lines_reg <= lines_reg + ITPJ_ONE;
  end
  assign out_field = field_reg;

  // ==========================================================
  // hsync jitter detector
  logic [1:0]  llen_reg, plen_reg;
  logic [7:0]  jcnt_reg;
  logic        in_area, mon, jit_ev;
  assign in_area = (lines_reg >= v_off) && (lines_reg < v_off + v_len);
  assign mon     = !in_form_on || in_area;
  assign jit_ev  = hs_rise && mon && (llen_reg != plen_reg);
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      llen_reg <= 2'b00;
      plen_reg <= 2'b00;
    end
    else if (hs_rise)
    begin
      llen_reg <= 2'b01;
      plen_reg <= llen_reg;
    end
    else
      llen_reg <= llen_reg + 2'b01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset || vs_rise)
      jcnt_reg <= 8'h00;
    else if (jit_ev && jcnt_reg != 8'hFF)
      jcnt_reg <= jcnt_reg + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      irq_state_reg <= 1'b0;
    else if (jcnt_reg > jit_reg[7:0] && !vs_rise)
      irq_state_reg <= 1'b1; // set wins over clear; vsync always ends the frame's level
    else if (vs_rise || clr_write)
      irq_state_reg <= 1'b0;
  end
  assign jitter_irq = irq_state_reg && irq_en;

  // ==========================================================
  // checks
  property p_irq_set;
    @(posedge sys_clk) disable iff (reset)
      (jcnt_reg > jit_reg[7:0] && !vs_rise) |=> irq_state_reg;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("jitter state not set");
  property p_vs_clr;
    @(posedge sys_clk) disable iff (reset) vs_rise |=> !irq_state_reg;
  endproperty
  a_vs_clr: assert property (p_vs_clr) else $error("jitter state kept past vsync");
  property p_irq_mask;
    @(posedge sys_clk) disable iff (reset) !irq_en |-> !jitter_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");
  property p_clr;
    @(posedge sys_clk) disable iff (reset)
      (clr_write && jcnt_reg <= jit_reg[7:0]) |=> !irq_state_reg;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_acc_rst;
    @(posedge sys_clk) disable iff (reset) vs_rise |=> jcnt_reg == 8'h00;
  endproperty
  a_acc_rst: assert property (p_acc_rst) else $error("accumulator not cleared");
  property p_ev_cnt;
    @(posedge sys_clk) disable iff (reset)
      (jit_ev && !vs_rise && jcnt_reg < 8'hFF) |=> jcnt_reg == $past(jcnt_reg) + 8'h01;
  endproperty
  a_ev_cnt: assert property (p_ev_cnt) else $error("event not counted");
  property p_test_out;
    @(posedge sys_clk) disable iff (reset)
      (test_on && g_act) |=> out_valid && out_pix.r == $past(gen_c[2]);
  endproperty
  a_test_out: assert property (p_test_out) else $error("generated pixel missing");
  property p_total;
    @(posedge sys_clk) disable iff (reset)
      (test_on && $past(test_on) && h_total > 12'h001 && col_reg + ITPJ_ONE >= h_total)
      |=> col_reg == 12'h000;
  endproperty
  a_total: assert property (p_total) else $error("line total wrong");
  property p_blank;
    @(posedge sys_clk) disable iff (reset)
      (test_on && col_reg >= h_len) |=> !out_valid;
  endproperty
  a_blank: assert property (p_blank) else $error("blank marked active");
  property p_inv;
    @(posedge sys_clk) disable iff (reset)
      (!invert && !border_px && hramp_en == 3'b000 && vramp_en == 3'b000) |-> gen_c[0] == 8'h00;
  endproperty
  a_inv: assert property (p_inv) else $error("disabled pattern leaks");
  c_irq: cover property (@(posedge sys_clk) disable iff (reset) $rose(jitter_irq));
  c_test: cover property (@(posedge sys_clk) disable iff (reset) test_on && g_act);
  c_field: cover property (@(posedge sys_clk) disable iff (reset) $rose(field_reg));
endmodule
`default_nettype wire

//--- itpj_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module itpj_src_model
  import itpj_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            reset,
  // shape of the traffic
  input  wire logic            jit_on,
  input  wire logic            alt_frames,
  // source pins
  output itpj_pkg::itpj_pix_t  src_pix,
  output itpj_pkg::itpj_sync_t src_sync
);
  import itpj_pkg::*;
  logic [7:0] h_reg;
  logic [7:0] line_reg;
  logic       odd_reg;
  logic [7:0] h_last;
  logic [7:0] n_lines;
  // ====
  // line and frame timing
  assign h_last  = 8'h13 + {7'h00, jit_on & line_reg[0]};
  assign n_lines = 8'h0A + {7'h00, alt_frames & odd_reg};
  always_ff @(posedge sys_clk)
  begin
    if (reset || h_reg == h_last)
      h_reg <= 8'h00;
    else
      h_reg <= h_reg + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      line_reg <= 8'h00;
    else if (h_reg == h_last)
      line_reg <= (line_reg == n_lines - 8'h01) ? 8'h00 : line_reg + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      odd_reg <= 1'b0;
    else if (h_reg == h_last && line_reg == n_lines - 8'h01)
      odd_reg <= ~odd_reg;
  end
  // ====
  // pins: vsync always supplied, pixels change every cycle
  assign src_sync = '{hsync: h_reg < 8'h02, vsync: line_reg == 8'h00, valid: h_reg >= 8'h02};
  assign src_pix  = '{r: h_reg, g: ~h_reg, b: line_reg};
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import itpj_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic jit_on = 1'b0;
  logic alt_frames = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, out_valid, out_field, jitter_irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  itpj_pix_t src_pix, out_pix;
  itpj_sync_t src_sync;
  int failures = 0;
  int checked = 0;
  always #25 sys_clk = ~sys_clk;
  itpj_src_model src (.sys_clk(sys_clk), .reset(reset), .jit_on(jit_on),
    .alt_frames(alt_frames), .src_pix(src_pix), .src_sync(src_sync));
  itpj_top dut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_pix(src_pix), .src_sync(src_sync), .out_pix(out_pix),
    .out_valid(out_valid), .out_field(out_field), .jitter_irq(jitter_irq));
  // ====
  // bus and reporting
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    bready <= 1'b1;
    do
      @(posedge sys_clk);
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, ITPJ_RESP_OK});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do
      @(posedge sys_clk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do
      @(posedge sys_clk);
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(ITPJ_CTRL_ADDR, d, r);
    check(d, ITPJ_CTRL_RST);
    wr(ITPJ_HSIZE_ADDR, 32'h000A_0006);
    rd(ITPJ_HSIZE_ADDR, d, r);
    check(d, 32'h000A_0006);
    rd(8'h20, d, r);
    check({30'h0, r}, {30'h0, ITPJ_RESP_ERR});
    check(d, ITPJ_ZERO);
  endtask
  task automatic t_border();
    int n;
    int w;
    int bad;
    n = 0;
    w = 0;
    bad = 0;
    wr(ITPJ_VSIZE_ADDR, 32'h0007_0004);
    wr(ITPJ_OFFS_ADDR, 32'h0003_0002);
    wr(ITPJ_CTRL_ADDR, 32'h0000_0013);
    repeat (150) @(posedge sys_clk);
    // one whole frame period holds exactly one active picture
    for (int i = 0; i < 70; i++)
    begin
      @(posedge sys_clk);
      if (out_valid === 1'b1)
      begin
        n++;
        if (out_pix.r === ITPJ_WHITE)
          w++;
        if (out_pix.g !== out_pix.r || out_pix.b !== out_pix.r
            || (out_pix.r !== 8'h00 && out_pix.r !== ITPJ_WHITE))
          bad++;
      end
    end
    check(n, 24);
    check(w, 16);
    check(bad, 0);
  endtask
  task automatic t_ramp();
    logic [9:0] m;
    logic [1:0] nz;
    int bad;
    wr(ITPJ_HRAMP_ADDR, 32'h0050_0001);
    wr(ITPJ_VRAMP_ADDR, 32'h0040_0001);
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(ITPJ_CTRL_ADDR, 32'h0000_1403 | (32'(inv) << ITPJ_B_INVERT));
      nz = 2'b00;
      bad = 0;
      repeat (150) @(posedge sys_clk);
      for (int i = 0; i < 70; i++)
      begin
        @(posedge sys_clk);
        if (out_valid === 1'b1)
        begin
          m = (inv == 1) ? {out_pix.r[7:4], out_pix.g[7:2]} : {out_pix.r[3:0], out_pix.g[5:0]};
          if (m !== 10'h000 || out_pix.b !== 8'h00)
            bad++;
          nz = nz | {out_pix.r != 8'h00, out_pix.g != 8'h00};
        end
      end
      check(bad, 0);
      check({30'h0, nz}, 32'h0000_0003);
    end
  endtask
  task automatic watch_irq(output int seen);
    seen = 0;
    repeat (700) @(posedge sys_clk);
    for (int i = 0; i < 500; i++)
    begin
      @(posedge sys_clk);
      if (jitter_irq === 1'b1)
        seen++;
    end
  endtask
  task automatic t_jitter();
    logic [31:0] d;
    logic [1:0] r;
    int seen;
    wr(ITPJ_JIT_ADDR, 32'h0000_0001);
    wr(ITPJ_CTRL_ADDR, 32'h0001_0000);
    jit_on <= 1'b1;
    watch_irq(seen);
    check(32'(seen > 0), 1);
    // read just after a fresh rise, well before the next vsync
    while (jitter_irq !== 1'b0)
      @(posedge sys_clk);
    while (jitter_irq !== 1'b1)
      @(posedge sys_clk);
    rd(ITPJ_STAT_ADDR, d, r);
    check({31'h0, d[0]}, 1);
    // raise the limit so set no longer wins, then clear mid-frame
    wr(ITPJ_JIT_ADDR, 32'h0000_00FF);
    wr(ITPJ_STAT_ADDR, 32'h0000_0001);
    rd(ITPJ_STAT_ADDR, d, r);
    check({31'h0, d[0]}, 0);
    wr(ITPJ_JIT_ADDR, 32'h0000_0001);
    wr(ITPJ_CTRL_ADDR, ITPJ_ZERO);
    repeat (3) @(posedge sys_clk);
    check({31'h0, jitter_irq}, 0);
    rd(ITPJ_STAT_ADDR, d, r);
    check({31'h0, d[0]}, 0);
    jit_on <= 1'b0;
    wr(ITPJ_CTRL_ADDR, 32'h0001_0000);
    wr(ITPJ_STAT_ADDR, 32'h0000_0001);
    watch_irq(seen);
    check(seen, 0);
  endtask
  task automatic t_field();
    logic [1:0] seen;
    int n;
    int bad;
    seen = 2'b00;
    n = 0;
    bad = 0;
    wr(ITPJ_VSIZE_ADDR, 32'h000B_0005);
    wr(ITPJ_CTRL_ADDR, 32'h0000_0005);
    alt_frames <= 1'b1;
    repeat (500) @(posedge sys_clk);
    for (int i = 0; i < 1500; i++)
    begin
      @(posedge sys_clk);
      if (out_field === 1'b1)
        seen[1] = 1'b1;
      if (out_field === 1'b0)
        seen[0] = 1'b1;
      // source path: green is the inverse of red in every sampled pixel
      if (out_valid === 1'b1)
      begin
        n++;
        if (out_pix.g !== ~out_pix.r)
          bad++;
      end
    end
    check({30'h0, seen}, 32'h0000_0003);
    check(32'(n > 0), 1);
    check(bad, 0);
  endtask
  // ====
  // main sequence and watchdog
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_border();
    t_ramp();
    t_jitter();
    t_field();
    conclude();
  end
  initial
  begin
    // generous margin over the roughly five thousand cycles expected
    #(20000 * 50);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
